// *** inc/bt_pkg.sv ***
// Shared constants, register map and telegram carrier for the bus telegram control block.
// Assumes a single 20 MHz system clock; all timers derive from it.
package bt_pkg;
	// Clock and tick timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned MS_TICK_NS = 1000000;
	localparam int unsigned CYC_PER_MS = (MS_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned MS_PER_S = 1000;
	localparam int unsigned S_PER_MIN = 60;

	// Register byte offsets
	localparam logic [7:0] ADDR_CFG0 = 8'h00;
	localparam logic [7:0] ADDR_CFG1 = 8'h04;
	localparam logic [7:0] ADDR_CFG2 = 8'h08;
	localparam logic [7:0] ADDR_CFG3 = 8'h0c;
	localparam logic [7:0] ADDR_CTRL = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;

	// CFG0: send delay [7:0], limit enable [8], limit count [23:16], period select [27:24]
	localparam int unsigned F_DLY = 0;
	localparam int unsigned F_LIM_EN = 8;
	localparam int unsigned F_LIM_CNT = 16;
	localparam int unsigned F_PER = 24;
	// CFG1: heartbeat mode [1:0], poll enable [2], poll value [4:3], manual mode [6:5],
	// manual timeout [9:7], power-save timeout [12:10], heartbeat cycle [31:16]
	localparam int unsigned F_HB = 0;
	localparam int unsigned F_POLL_EN = 2;
	localparam int unsigned F_POLL_VAL = 3;
	localparam int unsigned F_MAN = 5;
	localparam int unsigned F_MAN_TMO = 7;
	localparam int unsigned F_SAVE_TMO = 10;
	localparam int unsigned F_HB_CYC = 16;
	// CFG2: button mode 2 bits per input [15:0], LED mode 2 bits per input [31:16]
	localparam int unsigned F_BTN = 0;
	localparam int unsigned F_LED = 16;
	// CFG3: status send mode [1:0], input block [15:8], switching delay [31:24]
	localparam int unsigned F_STAT = 0;
	localparam int unsigned F_BLK = 8;
	localparam int unsigned F_SW_DLY = 24;
	// CTRL: programming / download strobe [0]
	localparam int unsigned F_PROG = 0;

	localparam logic [31:0] CFG0_RST = 32'h0414_0002;
	localparam logic [31:0] CFG1_RST = 32'h003c_0008;
	localparam logic [31:0] CFG2_RST = 32'h0000_5555;
	localparam logic [31:0] CFG3_RST = 32'h0000_0000;

	// Field encodings
	localparam logic [1:0] HB_OFF = 2'h0;
	localparam logic [1:0] HB_SEND0 = 2'h1;
	localparam logic [1:0] HB_SEND1 = 2'h2;
	localparam logic [1:0] POLL_0 = 2'h0;
	localparam logic [1:0] POLL_1 = 2'h1;
	localparam logic [1:0] POLL_ANY = 2'h2;
	localparam logic [1:0] MAN_ENABLED = 2'h0;
	localparam logic [1:0] MAN_DISABLED = 2'h1;
	localparam logic [1:0] MAN_VIA_OBJ = 2'h2;
	localparam logic [1:0] STAT_UPDATE = 2'h0;
	localparam logic [1:0] STAT_CHG = 2'h1;
	localparam logic [1:0] STAT_REQ = 2'h2;
	localparam logic [1:0] STAT_CHG_REQ = 2'h3;
	localparam logic [1:0] BTN_DIS = 2'h0;
	localparam logic [1:0] BTN_TOGGLE = 2'h1;
	localparam logic [1:0] BTN_MOMENT = 2'h2;
	localparam logic [1:0] LED_NORMAL = 2'h0;
	localparam logic [1:0] LED_DIS = 2'h1;
	localparam logic [1:0] LED_INV = 2'h2;

	// Received object selectors
	localparam logic RX_POLL = 1'h0;
	localparam logic RX_LOCK = 1'h1;

	typedef enum logic [1:0] {TK_RESP, TK_STAT, TK_HB, TK_EVT} bt_kind_type;
	typedef enum logic {OP_BUS, OP_MANUAL} bt_op_type;

	typedef struct packed {
		bt_kind_type kind;
		logic [2:0] idx;
		logic val;
	} bt_tel_type;

	// Limiting period in ms: 50 ms .. 1 min
	function automatic logic [15:0] bt_period_ms(input logic [3:0] sel);
		case (sel)
			4'h0: return 16'd50;
			4'h1: return 16'd100;
			4'h2: return 16'd200;
			4'h3: return 16'd500;
			4'h4: return 16'd1000;
			4'h5: return 16'd2000;
			4'h6: return 16'd5000;
			4'h7: return 16'd10000;
			4'h8: return 16'd20000;
			4'h9: return 16'd30000;
			default: return 16'd60000;
		endcase
	endfunction

	// Timeout code to minutes: none, 1, 3, 10, 30
	function automatic logic [4:0] bt_minutes(input logic [2:0] code);
		case (code)
			3'h1: return 5'd1;
			3'h2: return 5'd3;
			3'h3: return 5'd10;
			3'h4: return 5'd30;
			default: return 5'd0;
		endcase
	endfunction
endpackage

// *** hdl/bt_tick.sv ***
// Common prescaler producing one-cycle millisecond, second and minute ticks.
// Assumes hclk at the rate in the package; counts are shortened by parameters in simulation.
`timescale 1ns/100ps
module bt_tick #(
	parameter int unsigned CYC_MS = 20000,
	parameter int unsigned MS_S = 1000,
	parameter int unsigned S_MIN = 60
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Asynchronous reset, active low
	output logic ms_tick, // One pulse per millisecond
	output logic s_tick, // One pulse per second
	output logic min_tick // One pulse per minute
);
	localparam int unsigned CW = $clog2(CYC_MS + 1);
	localparam int unsigned MW = $clog2(MS_S + 1);
	localparam int unsigned SW = $clog2(S_MIN + 1);

	logic [CW-1:0] cyc_q;
	logic [MW-1:0] ms_q;
	logic [SW-1:0] s_q;
	logic ms_end, s_end, min_end;

	assign ms_end = (cyc_q == CW'(CYC_MS - 1));
	assign s_end = ms_end && (ms_q == MW'(MS_S - 1));
	assign min_end = s_end && (s_q == SW'(S_MIN - 1));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_q <= '0;
			ms_q <= '0;
			s_q <= '0;
			ms_tick <= 1'b0;
			s_tick <= 1'b0;
			min_tick <= 1'b0;
		end else begin
			cyc_q <= ms_end ? '0 : cyc_q + CW'(1);
			if (ms_end)
				ms_q <= (ms_q == MW'(MS_S - 1)) ? '0 : ms_q + MW'(1);
			if (s_end)
				s_q <= (s_q == SW'(S_MIN - 1)) ? '0 : s_q + SW'(1);
			ms_tick <= ms_end;
			s_tick <= s_end;
			min_tick <= min_end;
		end
	end
endmodule

// *** hdl/bt_ctrl.sv ***
// Telegram hold-off, rate limiting, heartbeat, status poll, manual mode and LED control.
// Assumes a bus transceiver on the same clock that hands over received objects
// and accepts telegrams by valid/ready; pins pass a three-stage synchroniser.
//
// Overview of operation
// R1: no telegram before send delay elapses
// R2: delay 2..255 s; hold reads, drop received
// R3: limit telegrams per selectable period
// R4: send pending telegrams at period start
// R5: blocked telegrams stay queued for later
// R6: heartbeat off, cyclic 0 or cyclic 1
// R7: heartbeat cycle 1..65535 s, default 60
// R8: first heartbeat after send and switching delay
// R9: matching poll sends request-mode status objects
// R10: poll value 0, 1 or either
// R11: manual switching enabled, disabled or object-controlled
// R12: lock 1 forces bus, 0 allows button
// R13: manual buttons override terminal input states
// R14: block detaches terminals and event object
// R15: block leaves manual operation unaffected
// R16: manual ends by button or timeout
// R17: power saving darkens LEDs in bus mode
// R18: any press wakes LEDs, timer restarts
// R19: bus switch-over, programming, reset wake LEDs
// R20: status object four send modes
// R21: button disabled, toggle or momentary
// R22: momentary closed while held, open released
// R23: simulated state acts as real terminal
// R24: normal LED follows contact
// R25: inverted LED opposes contact; disabled off
// R26: timers from common tick, cleared on reset
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
module bt_ctrl import bt_pkg::*; #(
	parameter int unsigned N = 8,
	parameter int unsigned CYC_MS = CYC_PER_MS,
	parameter int unsigned MS_S = MS_PER_S,
	parameter int unsigned S_MIN = S_PER_MIN
) (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Asynchronous reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [7:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, word only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic [31:0] hrdata, // AHB read data
	output logic hresp, // AHB response, always OKAY
	input wire logic bus_ok, // Bus supply present (pin)
	input wire logic [N-1:0] term_in, // Input terminals (pins)
	input wire logic [N-1:0] btn_in, // Front buttons, high when pressed (pins)
	input wire logic mode_btn, // Manual mode button, high when pressed (pin)
	input wire logic rx_valid, // Received object strobe
	input wire logic rx_obj, // Received object: poll or lock
	input wire logic rx_val, // Received object value
	input wire logic rd_req, // Read request for the status object
	input wire logic tx_ready, // Transceiver takes telegram
	output logic tx_valid, // Telegram offered
	output bt_tel_type tx_tel, // Telegram content
	output logic [N-1:0] in_state, // Input states to the application
	output logic [N-1:0] led, // Yellow input LEDs
	output logic man_led // Manual operation indicator
);
	if (N < 1 || N > 8) begin : g_chk
		$error("bt_ctrl: N must be 1..8");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register bus

	logic [31:0] cfg0_q, cfg1_q, cfg2_q, cfg3_q;
	logic wr_q;
	logic [7:0] wa_q;
	logic prog_q;
	logic ap;
	logic [31:0] stat_w;
	logic dly_act_q, dark_q, lock_q;
	logic [7:0] sent_q;
	bt_op_type op_q;

	assign ap = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wa_q <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready) begin
				wr_q <= ap && hwrite;
				wa_q <= haddr;
			end
			if (ap && !hwrite) begin
				case (haddr)
					ADDR_CFG0: hrdata <= cfg0_q;
					ADDR_CFG1: hrdata <= cfg1_q;
					ADDR_CFG2: hrdata <= cfg2_q;
					ADDR_CFG3: hrdata <= cfg3_q;
					ADDR_STAT: hrdata <= stat_w;
					default: hrdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cfg0_q <= CFG0_RST;
			cfg1_q <= CFG1_RST;
			cfg2_q <= CFG2_RST;
			cfg3_q <= CFG3_RST;
			prog_q <= 1'b0;
		end else begin
			prog_q <= wr_q && (wa_q == ADDR_CTRL) && hwdata[F_PROG];
			if (wr_q) begin
				case (wa_q)
					ADDR_CFG0: cfg0_q <= hwdata;
					ADDR_CFG1: cfg1_q <= hwdata;
					ADDR_CFG2: cfg2_q <= hwdata;
					ADDR_CFG3: cfg3_q <= hwdata;
					default: ;
				endcase
			end
		end
	end

	// Configuration fields
	logic [7:0] send_dly, lim_cnt, sw_dly, blk;
	logic lim_en, poll_en;
	logic [3:0] per_sel;
	logic [1:0] hb_mode, poll_val, man_mode, stat_mode;
	logic [2:0] man_tmo, save_tmo;
	logic [15:0] hb_cyc;

	assign send_dly = cfg0_q[F_DLY +: 8];
	assign lim_en = cfg0_q[F_LIM_EN];
	assign lim_cnt = cfg0_q[F_LIM_CNT +: 8];
	assign per_sel = cfg0_q[F_PER +: 4];
	assign hb_mode = cfg1_q[F_HB +: 2];
	assign poll_en = cfg1_q[F_POLL_EN];
	assign poll_val = cfg1_q[F_POLL_VAL +: 2];
	assign man_mode = cfg1_q[F_MAN +: 2];
	assign man_tmo = cfg1_q[F_MAN_TMO +: 3];
	assign save_tmo = cfg1_q[F_SAVE_TMO +: 3];
	assign hb_cyc = cfg1_q[F_HB_CYC +: 16];
	assign stat_mode = cfg3_q[F_STAT +: 2];
	assign blk = cfg3_q[F_BLK +: 8];
	assign sw_dly = cfg3_q[F_SW_DLY +: 8];

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and ticks

	localparam int unsigned PW = 2 * N + 2;
	logic [PW-1:0] s1_q, s2_q, s3_q, pin_q, pin_prev_q;
	logic [N-1:0] term, btn, btn_rise;
	logic mb_rise, bus_up, any_press;
	logic ms_tick, s_tick, min_tick;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			pin_q <= '0;
			pin_prev_q <= '0;
		end else begin
			s1_q <= {bus_ok, mode_btn, btn_in, term_in};
			s2_q <= s1_q;
			s3_q <= s2_q;
			pin_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
			pin_prev_q <= pin_q;
		end
	end

	assign term = pin_q[N-1:0];
	assign btn = pin_q[2*N-1:N];
	assign btn_rise = btn & ~pin_prev_q[2*N-1:N];
	assign mb_rise = pin_q[2*N] && !pin_prev_q[2*N];
	assign bus_up = pin_q[2*N+1];
	assign any_press = mb_rise || (|btn_rise);

	bt_tick #(.CYC_MS(CYC_MS), .MS_S(MS_S), .S_MIN(S_MIN)) u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.ms_tick(ms_tick), // R26
		.s_tick(s_tick),
		.min_tick(min_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Bus recovery delays

	logic [7:0] rec_s_q;
	logic sw_done;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rec_s_q <= '0;
			dly_act_q <= 1'b1;
		end else if (!bus_up) begin
			rec_s_q <= '0;
			dly_act_q <= 1'b1;
		end else begin
			if (s_tick && rec_s_q != 8'hff)
				rec_s_q <= rec_s_q + 8'h01;
			dly_act_q <= rec_s_q < send_dly; // R1 R2
		end
	end

	assign sw_done = !dly_act_q && (rec_s_q >= sw_dly); // R8

	////////////////////////////////////////////////////////////////////////////////
	// Telegram queue and limiter

	logic [15:0] per_ms_q, hb_cnt_q;
	logic hb_first_q, hb_pend_q, stat_pend_q, resp_pend_q;
	logic [N-1:0] evt_pend_q, evt_clr, evt_set, eff_q;
	logic can_send, tx_load, poll_hit, stat_chg;
	logic hb_clr, stat_clr, resp_clr;
	bt_tel_type tel_d;

	assign can_send = !dly_act_q && (!lim_en || sent_q < lim_cnt); // R1 R3
	assign tx_load = can_send && (!tx_valid || tx_ready) &&
		(resp_pend_q || stat_pend_q || hb_pend_q || (|evt_pend_q)); // R4

	always_comb begin
		tel_d = '{kind: TK_EVT, idx: 3'h0, val: 1'b0};
		hb_clr = 1'b0;
		stat_clr = 1'b0;
		resp_clr = 1'b0;
		evt_clr = '0;
		if (resp_pend_q) begin
			tel_d = '{kind: TK_RESP, idx: 3'h0, val: op_q == OP_MANUAL};
			resp_clr = tx_load;
		end else if (stat_pend_q) begin
			tel_d = '{kind: TK_STAT, idx: 3'h0, val: op_q == OP_MANUAL};
			stat_clr = tx_load;
		end else if (hb_pend_q) begin
			tel_d = '{kind: TK_HB, idx: 3'h0, val: hb_mode == HB_SEND1}; // R6
			hb_clr = tx_load;
		end else begin
			for (int i = N - 1; i >= 0; i--) begin
				if (evt_pend_q[i]) begin
					tel_d = '{kind: TK_EVT, idx: 3'(i), val: eff_q[i]};
					evt_clr = '0;
					evt_clr[i] = tx_load;
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_valid <= 1'b0;
			tx_tel <= '0;
		end else if (tx_load) begin
			tx_valid <= 1'b1;
			tx_tel <= tel_d;
		end else if (tx_ready) begin
			tx_valid <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			per_ms_q <= '0;
			sent_q <= '0;
		end else if (ms_tick && per_ms_q + 16'h0001 >= bt_period_ms(per_sel)) begin
			per_ms_q <= '0;
			sent_q <= {7'h00, tx_load}; // R3 R4
		end else begin
			if (ms_tick)
				per_ms_q <= per_ms_q + 16'h0001;
			if (tx_load && sent_q != 8'hff)
				sent_q <= sent_q + 8'h01;
		end
	end

	// Pending flags: a new request in the clearing cycle survives
	assign poll_hit = rx_valid && rx_obj == RX_POLL && !dly_act_q && poll_en &&
		(poll_val == POLL_ANY || poll_val == {1'b0, rx_val}); // R2 R10
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resp_pend_q <= 1'b0;
			stat_pend_q <= 1'b0;
			evt_pend_q <= '0;
		end else begin
			resp_pend_q <= (resp_pend_q && !resp_clr) || rd_req; // R2 R5
			stat_pend_q <= (stat_pend_q && !stat_clr) ||
				(stat_chg && stat_mode[0]) || // R20
				(poll_hit && stat_mode[1]); // R9
			evt_pend_q <= (evt_pend_q & ~evt_clr) | evt_set; // R5
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hb_pend_q <= 1'b0;
			hb_first_q <= 1'b0;
			hb_cnt_q <= '0;
		end else begin
			hb_pend_q <= hb_pend_q && !hb_clr;
			if (hb_mode == HB_OFF || !sw_done) begin
				hb_first_q <= 1'b0;
				hb_cnt_q <= '0;
			end else if (!hb_first_q) begin
				hb_first_q <= 1'b1;
				hb_pend_q <= 1'b1; // R8
			end else if (s_tick) begin
				if (hb_cnt_q + 16'h0001 >= hb_cyc) begin
					hb_cnt_q <= '0;
					hb_pend_q <= 1'b1; // R7
				end else begin
					hb_cnt_q <= hb_cnt_q + 16'h0001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Manual operation

	logic man_allowed, man_exit, man_enter;
	logic [4:0] man_min_q, save_min_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			lock_q <= 1'b0;
		else if (rx_valid && rx_obj == RX_LOCK && !dly_act_q)
			lock_q <= rx_val;
	end

	assign man_allowed = man_mode == MAN_ENABLED || (man_mode == MAN_VIA_OBJ && !lock_q); // R11 R12
	assign man_enter = op_q == OP_BUS && mb_rise && man_allowed;
	assign man_exit = op_q == OP_MANUAL && (!man_allowed || mb_rise ||
		(bt_minutes(man_tmo) != 5'h0 && man_min_q >= bt_minutes(man_tmo))); // R16
	assign stat_chg = man_enter || man_exit;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_q <= OP_BUS;
			man_min_q <= '0;
		end else begin
			if (man_enter)
				op_q <= OP_MANUAL;
			else if (man_exit)
				op_q <= OP_BUS; // R12
			if (any_press || op_q == OP_BUS)
				man_min_q <= '0;
			else if (min_tick && man_min_q != 5'h1f)
				man_min_q <= man_min_q + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input simulation, blocking and events

	logic [N-1:0] sim_q, eff_d;

	always_comb begin
		for (int i = 0; i < N; i++) begin
			if (op_q == OP_MANUAL && cfg2_q[F_BTN + 2*i +: 2] != BTN_DIS)
				eff_d[i] = sim_q[i]; // R13 R15
			else if (blk[i])
				eff_d[i] = eff_q[i]; // R14
			else
				eff_d[i] = term[i];
		end
	end
	assign evt_set = eff_d ^ eff_q; // R23

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sim_q <= '0;
			eff_q <= '0;
		end else begin
			eff_q <= eff_d;
			for (int i = 0; i < N; i++) begin
				if (op_q != OP_MANUAL)
					sim_q[i] <= eff_q[i];
				else if (cfg2_q[F_BTN + 2*i +: 2] == BTN_TOGGLE && btn_rise[i])
					sim_q[i] <= !sim_q[i]; // R21
				else if (cfg2_q[F_BTN + 2*i +: 2] == BTN_MOMENT)
					sim_q[i] <= btn[i]; // R22
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Power saving and LEDs

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			save_min_q <= '0;
			dark_q <= 1'b0; // R19
		end else if (any_press || man_exit || prog_q || op_q == OP_MANUAL) begin
			save_min_q <= '0;
			dark_q <= 1'b0; // R18 R19
		end else begin
			if (min_tick && save_min_q != 5'h1f)
				save_min_q <= save_min_q + 5'h01;
			dark_q <= bt_minutes(save_tmo) != 5'h0 && save_min_q >= bt_minutes(save_tmo); // R17
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			led <= '0;
			in_state <= '0;
			man_led <= 1'b0;
		end else begin
			in_state <= eff_q;
			man_led <= op_q == OP_MANUAL;
			for (int i = 0; i < N; i++) begin
				case (cfg2_q[F_LED + 2*i +: 2])
					LED_NORMAL: led[i] <= !dark_q && eff_q[i]; // R24
					LED_INV: led[i] <= !dark_q && !eff_q[i]; // R25
					default: led[i] <= 1'b0; // R25
				endcase
			end
		end
	end

	assign stat_w = {8'h00, 8'(eff_q), sent_q, 4'h0, lock_q, dark_q, op_q == OP_MANUAL, dly_act_q};

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_held;
		op_q == OP_MANUAL && cfg2_q[F_BTN +: 2] == BTN_MOMENT && btn[0];
	endsequence
	sequence s_sim_closed;
		##1 (sim_q[0] && eff_q[0]);
	endsequence

	no_send_delay_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
		tx_load |-> !dly_act_q) else $error("telegram launched during send delay");
	limit_cap_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
		tx_load |-> !lim_en || sent_q < lim_cnt) else $error("period limit exceeded");
	burst_start_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
		(can_send && !tx_valid && (hb_pend_q || stat_pend_q)) |=> tx_valid)
		else $error("pending telegram not sent at once");
	queue_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) // R5
		(hb_pend_q && !tx_load) |=> hb_pend_q) else $error("heartbeat dropped");
	hb_value_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
		(tx_load && tel_d.kind == TK_HB) |=> tx_tel.val == ($past(hb_mode) == HB_SEND1))
		else $error("heartbeat value wrong");
	poll_react_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
		(poll_hit && stat_mode == STAT_REQ) |=> stat_pend_q) else $error("poll ignored");
	lock_force_a: assert property (@(posedge hclk) disable iff (!hresetn) // R12
		(man_mode == MAN_VIA_OBJ && lock_q && op_q == OP_MANUAL) |=> op_q == OP_BUS)
		else $error("lock did not force bus operation");
	moment_sim_a: assert property (@(posedge hclk) disable iff (!hresetn) // R22
		(s_held ##1 s_held) |-> s_sim_closed) else $error("momentary input not closed");
	led_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // R25
		(cfg2_q[F_LED +: 2] == LED_DIS) |=> !led[0]) else $error("disabled LED lit");
	wake_a: assert property (@(posedge hclk) disable iff (!hresetn) // R18
		any_press |=> !dark_q [*2]) else $error("press did not wake LEDs");
endmodule

// *** sim/bt_bus_model.sv ***
// Bus transceiver and peer model: takes offered telegrams promptly or slowly.
// Assumes the control block's valid/ready telegram port on hclk.
`timescale 1ns/100ps
module bt_bus_model import bt_pkg::*; (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic slow, // Accept only every fourth cycle
	input wire logic tx_valid, // Telegram offered
	input wire bt_tel_type tx_tel, // Telegram content
	output logic tx_ready, // Telegram taken
	output int taken, // Telegrams taken
	output bt_tel_type last // Last telegram taken
);
	logic [1:0] ph_q;
	assign tx_ready = !slow || (ph_q == 2'h3);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q <= 2'h0;
			taken <= 0;
			last <= '0;
		end else begin
			ph_q <= ph_q + 2'h1;
			if (tx_valid && tx_ready) begin
				taken <= taken + 1;
				last <= tx_tel;
			end
		end
	end
endmodule

// *** sim/tb_bt_ctrl.sv ***
// Self-checking bench for the bus telegram and manual mode control block.
// Assumes shortened tick counts: 1 ms = 4 cycles, 1 s = 20, 1 min = 60.
`timescale 1ns/100ps
module tb_bt_ctrl import bt_pkg::*;;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, r;
	logic bus_ok = 1, mode_btn = 0, rx_valid = 0, rx_obj = 0, rx_val = 0, rd_req = 0;
	logic slow = 0, tx_ready, tx_valid, man_led;
	logic [7:0] term_in = 8'h00, btn_in = 8'h00, in_state, led;
	bt_tel_type tx_tel, last;
	int taken, num_errors = 0, checked = 0;
	assign hready = hreadyout;
	always #25 hclk = ~hclk;
	bt_ctrl #(.N(8), .CYC_MS(4), .MS_S(5), .S_MIN(3)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .bus_ok(bus_ok), .term_in(term_in), .btn_in(btn_in),
		.mode_btn(mode_btn), .rx_valid(rx_valid), .rx_obj(rx_obj), .rx_val(rx_val),
		.rd_req(rd_req), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_tel(tx_tel),
		.in_state(in_state), .led(led), .man_led(man_led));
	bt_bus_model peer (.hclk(hclk), .hresetn(hresetn), .slow(slow), .tx_valid(tx_valid),
		.tx_tel(tx_tel), .tx_ready(tx_ready), .taken(taken), .last(last));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	// Waits up to lim cycles for a new telegram; ok stays 0 if none came
	task automatic get_tel(input int lim, output logic ok);
		int t0;
		t0 = taken;
		ok = 0;
		repeat (lim) begin
			@(posedge hclk);
			#1;
			if (taken != t0) begin
				ok = 1;
				return;
			end
		end
	endtask
	task automatic press(input int i);
		@(posedge hclk);
		if (i < 0) mode_btn <= 1;
		else btn_in[i] <= 1;
		repeat (8) @(posedge hclk);
		mode_btn <= 0;
		btn_in <= 8'h00;
		repeat (8) @(posedge hclk);
	endtask
	task automatic rx(input logic o, input logic v);
		@(posedge hclk);
		rx_valid <= 1;
		rx_obj <= o;
		rx_val <= v;
		@(posedge hclk);
		rx_valid <= 0;
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_hb();
		logic ok;
		ahb(0, ADDR_CFG0, 0);
		chk("cfg0", CFG0_RST, r);
		ahb(0, 8'h40, 0);
		chk("unmapped", 32'h0, r);
		ahb(1, ADDR_CFG1, 32'h0001_0002);
		repeat (20) @(posedge hclk);
		ahb(0, ADDR_STAT, 0);
		chk("delay flag", 32'h1, {31'h0, r[0]});
		chk("held tx", 32'h0, {31'h0, tx_valid});
		get_tel(120, ok);
		chk("hb kind", {29'h0, 1'b1, TK_HB, 1'b1}, {ok, last.kind, last.val});
		ahb(1, ADDR_CFG1, 32'h0001_0001);
		get_tel(40, ok);
		get_tel(40, ok);
		chk("hb0", {29'h0, 1'b1, TK_HB, 1'b0}, {ok, last.kind, last.val});
	endtask
	task automatic t_limit();
		int t0;
		slow <= 1;
		ahb(1, ADDR_CFG0, 32'h0001_0102);
		repeat (200) @(posedge hclk);
		t0 = taken;
		repeat (1000) @(posedge hclk);
		chk("per period", 32'h1, {31'h0, taken - t0 >= 4 && taken - t0 <= 6});
		slow <= 0;
		ahb(1, ADDR_CFG0, CFG0_RST);
	endtask
	task automatic t_poll();
		logic ok;
		logic [1:0] v[3] = '{POLL_0, POLL_1, POLL_ANY};
		ahb(1, ADDR_CFG3, {30'h0, STAT_REQ});
		for (int k = 0; k < 3; k++) begin
			ahb(1, ADDR_CFG1, {27'h0, v[k], 3'h4});
			repeat (30) @(posedge hclk);
			rx(RX_POLL, k == 1);
			get_tel(30, ok);
			chk("poll hit", {29'h0, 1'b1, TK_STAT}, {ok, last.kind});
			rx(RX_POLL, k != 1);
			get_tel(30, ok);
			chk("poll miss", {31'h0, k == 2}, {31'h0, ok});
		end
	endtask
	task automatic t_led_manual();
		ahb(1, ADDR_CFG2, 32'h0024_5555);
		term_in <= 8'h03;
		repeat (12) @(posedge hclk);
		chk("led", 32'h5, {29'h0, led[2:0]});
		press(-1);
		chk("manual", 32'h1, {31'h0, man_led});
		press(0);
		chk("toggle", 32'h2, {29'h0, in_state[2:0]});
		press(-1);
		chk("leave", 32'h0, {31'h0, man_led});
		ahb(1, ADDR_CFG1, 32'h0000_0080);
		press(-1);
		repeat (100) @(posedge hclk);
		chk("timeout", 32'h0, {31'h0, man_led});
		ahb(1, ADDR_CFG1, 32'h0000_0020);
		press(-1);
		chk("disabled", 32'h0, {31'h0, man_led});
	endtask
	task automatic t_lock_save();
		ahb(1, ADDR_CFG1, 32'h0000_0040);
		press(-1);
		chk("lock 0", 32'h1, {31'h0, man_led});
		rx(RX_LOCK, 1);
		repeat (4) @(posedge hclk);
		chk("lock 1", 32'h0, {31'h0, man_led});
		press(-1);
		chk("locked", 32'h0, {31'h0, man_led});
		rx(RX_LOCK, 0);
		ahb(1, ADDR_CFG1, 32'h0000_0400);
		repeat (130) @(negedge hclk);
		chk("dark", 32'h0, {24'h0, led});
		ahb(1, ADDR_CTRL, 32'h0000_0001);
		for (int k = 0; k < 8 && led[2:0] !== 3'h5; k++) @(negedge hclk);
		chk("wake", 32'h5, {29'h0, led[2:0]});
		ahb(1, ADDR_CFG2, 32'h0025_5556);
		term_in <= 8'h02;
		ahb(1, ADDR_CFG1, 32'h0000_0000);
		press(-1);
		btn_in[0] <= 1;
		repeat (10) @(posedge hclk);
		chk("held", 32'h1, {31'h0, in_state[0]});
		chk("held led", 32'h0, {31'h0, led[0]});
		btn_in[0] <= 0;
		repeat (10) @(posedge hclk);
		chk("released", 32'h0, {31'h0, in_state[0]});
		press(-1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1;
		t_reset_hb();
		t_limit();
		t_poll();
		t_led_manual();
		t_lock_save();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		report_and_stop();
	end
endmodule
